/* File: flash_macro_model.sv */
// behavioural flash macro beside the sequencer
// assumes same clock; stalls every other cycle to exercise the handshake
`timescale 1ns/1ps
module flash_macro_model #(
    parameter int OP_CYC = 40
) (
    input  wire logic        i_sys_clk, // clock
    input  wire logic        i_nrst,    // reset
    input  wire logic [16:0] i_addr,    // macro address
    input  wire logic        i_wvalid,  // page byte valid
    input  wire logic [7:0]  i_wdata,   // page byte
    input  wire logic        i_prog,    // program pulse
    input  wire logic        i_erase,   // erase pulse
    input  wire logic        i_fail,    // make next op fail
    output logic [7:0]       o_rdata,   // array byte
    output logic             o_wready,  // takes byte
    output logic             o_done,    // op ended
    output logic             o_fail,    // op failed
    output logic [7:0]       o_cnt,     // bytes taken
    output logic [16:0]      o_first,   // first byte address
    output logic [16:0]      o_last,    // last byte address
    output logic [7:0]       o_ldata,   // last byte
    output logic             o_erased   // whole array erased
);
    int tmr;
    assign o_rdata = i_addr[7:0] ^ 8'h5a;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wready <= 1'b0;
            o_done <= 1'b0;
            o_fail <= 1'b0;
            o_cnt <= 8'h00;
            o_first <= 17'h00000;
            o_last <= 17'h00000;
            o_ldata <= 8'h00;
            o_erased <= 1'b0;
            tmr <= 0;
        end else begin
            o_wready <= ~o_wready;
            o_done <= (tmr == 1);
            o_fail <= (tmr == 1) && i_fail;
            if (i_wvalid && o_wready) begin
                if (o_cnt == 8'h00) o_first <= i_addr;
                o_cnt <= o_cnt + 8'h01;
                o_last <= i_addr;
                o_ldata <= i_wdata;
            end
            if (i_prog || i_erase) tmr <= OP_CYC;
            else if (tmr > 0) tmr <= tmr - 1;
            if (i_erase) o_erased <= 1'b1;
            if (tmr == 1) o_cnt <= 8'h00;
        end
    end
endmodule // flash_macro_model

/* File: flash_seq.sv */
// programmer mode sequencer and its byte fifo
// assumes pins come from an outside programmer; flash macro on same clock
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module byte_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         i_sys_clk,  // system clock
    input  wire logic         i_nrst,     // async reset, low
    input  wire logic         i_in_valid, // push request
    output logic              o_in_ready, // room left
    input  wire logic [W-1:0] i_in_data,  // pushed word
    output logic              o_out_valid,// word available
    input  wire logic         i_out_ready,// pop request
    output logic [W-1:0]      o_out_data  // head word
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_r;
    logic [PW-1:0] rd_r;
    logic [PW:0]   cnt_r;
    wire push = i_in_valid & o_in_ready;
    wire pop  = o_out_valid & i_out_ready;

    assign o_in_ready  = (cnt_r != (PW+1)'(DEPTH));
    assign o_out_valid = (cnt_r != '0);
    assign o_out_data  = mem[rd_r];

    always_ff @(posedge i_sys_clk) begin
        if (push)
            mem[wr_r] <= i_in_data;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push)
                wr_r <= (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            if (pop)
                rd_r <= (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            if (push & ~pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop & ~push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // byte_fifo

////////////////////////////////////////////////////////////////////////
module flash_seq #(
    parameter int SETUP_CYC = flash_seq_pkg::SETUP_CYC,
    parameter int ADDR_W    = flash_seq_pkg::ADDR_W,
    parameter int DEPTH     = flash_seq_pkg::FIFO_DEPTH
) (
    input  wire logic              i_sys_clk,    // 125 MHz clock
    input  wire logic              i_nrst,       // async reset, low
    input  wire logic              i_ce_n,       // chip enable pin
    input  wire logic              i_oe_n,       // output enable pin
    input  wire logic              i_we_n,       // write strobe pin
    input  wire logic [ADDR_W-1:0] i_addr,       // address pins
    input  wire logic [7:0]        i_data,       // data pins in
    output logic [7:0]             o_data,       // data pins out
    output logic                   o_data_oe,    // data pins driven
    output logic [ADDR_W-1:0]      o_mem_addr,   // macro address
    input  wire logic [7:0]        i_mem_rdata,  // macro read data
    output logic                   o_mem_wvalid, // page byte valid
    output logic [7:0]             o_mem_wdata,  // page byte
    input  wire logic              i_mem_wready, // macro takes byte
    output logic                   o_prog_start, // program page pulse
    output logic                   o_erase_start,// erase all pulse
    input  wire logic              i_op_done,    // macro op ended pulse
    input  wire logic              i_op_fail,    // with done: failed
    output logic                   o_busy        // op in progress
);
    localparam int PB = flash_seq_pkg::PAGE_LSB;
    localparam int SW = ADDR_W + 11;
    localparam int CW = $clog2(SETUP_CYC + 1);

    flash_seq_pkg::seq_state_e state_r;
    flash_seq_pkg::out_sel_e   sel_r;
    logic [SW-1:0]     s1_r;
    logic [SW-1:0]     s2_r;
    logic              we_d_r;
    logic [CW-1:0]     setup_r;
    logic [ADDR_W-1:0] base_r;
    logic [7:0]        in_cnt_r;
    logic [7:0]        acc_cnt_r;
    logic [PB-1:0]     ld_idx_r;
    logic [7:0]        sts_r;
    logic              done_r;
    logic              push_r;
    logic [7:0]        push_d_r;
    logic              fifo_in_rdy;
    logic              fifo_out_vld;
    logic [7:0]        fifo_out_dat;

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers on every pin
    wire              ce_s   = ~s2_r[SW-1];
    wire              oe_s   = ~s2_r[SW-2];
    wire              we_s   = s2_r[SW-3];
    wire [ADDR_W-1:0] addr_s = s2_r[ADDR_W+7:8];
    wire [7:0]        dat_s  = s2_r[7:0];
    // data sampled at the rising write edge; pins hold 50 ns after it
    wire wr_stb = we_s & ~we_d_r & ce_s;

    wire cmd_prog = (dat_s == flash_seq_pkg::CMD_PROG);
    wire cmd_ers  = (dat_s == flash_seq_pkg::CMD_ERASE);
    wire cmd_sts  = (dat_s == flash_seq_pkg::CMD_STATUS);
    wire cmd_rd   = (dat_s == flash_seq_pkg::CMD_READ);
    wire cmd_idle = (state_r == flash_seq_pkg::S_WAIT) |
                    (state_r == flash_seq_pkg::S_READ);
    wire misalign = (addr_s[PB-1:0] != '0);
    wire skid_ld  = fifo_out_vld & (~o_mem_wvalid | i_mem_wready);
    wire mem_acc  = o_mem_wvalid & i_mem_wready;
    wire abnormal = |sts_r[flash_seq_pkg::ST_PRG:0] |
                    sts_r[flash_seq_pkg::ST_CMD];
    wire [7:0] poll_byte = {done_r, done_r & ~abnormal, 6'h00};
    wire [7:0] sts_byte  = {abnormal, sts_r[6:0]};

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // strobes idle high, so no false write edge after reset
            s1_r   <= {3'h7, {(SW-3){1'b0}}};
            s2_r   <= {3'h7, {(SW-3){1'b0}}};
            we_d_r <= 1'b1;
        end else begin
            s1_r   <= {i_ce_n, i_oe_n, i_we_n, i_addr, i_data};
            s2_r   <= s1_r;
            we_d_r <= we_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // page bytes pass the fifo; a full fifo drops the byte and flags it
    byte_fifo #(
        .W     (8),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (push_r),
        .o_in_ready  (fifo_in_rdy),
        .i_in_data   (push_d_r),
        .o_out_valid (fifo_out_vld),
        .i_out_ready (skid_ld),
        .o_out_data  (fifo_out_dat)
    );

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mem_wvalid <= 1'b0;
            o_mem_wdata  <= 8'h00;
            ld_idx_r     <= '0;
            acc_cnt_r    <= 8'h00;
        end else begin
            if (skid_ld) begin
                o_mem_wvalid <= 1'b1;
                o_mem_wdata  <= fifo_out_dat;
                ld_idx_r     <= ld_idx_r + 1'b1;
            end else if (i_mem_wready)
                o_mem_wvalid <= 1'b0;
            if (state_r == flash_seq_pkg::S_PADDR)
                acc_cnt_r <= 8'h00;
            else if (mem_acc)
                acc_cnt_r <= acc_cnt_r + 1'b1;
            if (state_r == flash_seq_pkg::S_PADDR)
                ld_idx_r <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command sequencer
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r       <= flash_seq_pkg::S_SETUP;
            sel_r         <= flash_seq_pkg::OUT_NONE;
            setup_r       <= '0;
            base_r        <= '0;
            in_cnt_r      <= 8'h00;
            sts_r         <= flash_seq_pkg::STS_RST;
            done_r        <= 1'b0;
            push_r        <= 1'b0;
            push_d_r      <= 8'h00;
            o_prog_start  <= 1'b0;
            o_erase_start <= 1'b0;
        end else begin
            push_r        <= 1'b0;
            o_prog_start  <= 1'b0;
            o_erase_start <= 1'b0;
            unique case (state_r)
            flash_seq_pkg::S_SETUP: begin
                setup_r <= setup_r + 1'b1;
                if (setup_r == CW'(SETUP_CYC - 1)) begin
                    state_r <= flash_seq_pkg::S_READ;
                    sel_r   <= flash_seq_pkg::OUT_ARRAY;
                end
            end
            flash_seq_pkg::S_WAIT, flash_seq_pkg::S_READ: begin
                if (wr_stb) begin
                    if (!cmd_sts)
                        sts_r <= flash_seq_pkg::STS_RST;
                    sel_r <= flash_seq_pkg::OUT_NONE;
                    if (cmd_prog)
                        state_r <= flash_seq_pkg::S_PADDR;
                    else if (cmd_ers)
                        state_r <= flash_seq_pkg::S_ERS2;
                    else if (cmd_sts)
                        state_r <= flash_seq_pkg::S_STS2;
                    else if (cmd_rd) begin
                        state_r <= flash_seq_pkg::S_READ;
                        sel_r   <= flash_seq_pkg::OUT_ARRAY;
                    end else begin
                        // no operation starts on an unknown code
                        sts_r   <= 8'h00 | (8'h01 << flash_seq_pkg::ST_CMD);
                        state_r <= flash_seq_pkg::S_WAIT;
                        sel_r   <= flash_seq_pkg::OUT_STATUS;
                    end
                end
            end
            flash_seq_pkg::S_PADDR: begin
                if (wr_stb) begin
                    // block base latched only here
                    base_r   <= addr_s;
                    push_r   <= 1'b1;
                    push_d_r <= dat_s;
                    in_cnt_r <= 8'h01;
                    done_r   <= 1'b0;
                    sel_r    <= flash_seq_pkg::OUT_POLL;
                    state_r  <= flash_seq_pkg::S_PDATA;
                    if (misalign) begin
                        sts_r[flash_seq_pkg::ST_ADR] <= 1'b1;
                        sts_r[flash_seq_pkg::ST_PRG] <= 1'b1;
                    end
                end
            end
            flash_seq_pkg::S_PDATA: begin
                if (wr_stb) begin
                    push_r   <= 1'b1;
                    push_d_r <= dat_s;
                    in_cnt_r <= in_cnt_r + 1'b1;
                    if (in_cnt_r == 8'(flash_seq_pkg::PAGE_BYTES - 1))
                        state_r <= flash_seq_pkg::S_PDRAIN;
                end
                if (push_r & ~fifo_in_rdy)
                    sts_r[flash_seq_pkg::ST_PRG] <= 1'b1;
            end
            flash_seq_pkg::S_PDRAIN: begin
                if (push_r & ~fifo_in_rdy)
                    sts_r[flash_seq_pkg::ST_PRG] <= 1'b1;
                // whole page in the macro latch before programming
                if (acc_cnt_r == 8'(flash_seq_pkg::PAGE_BYTES)) begin
                    o_prog_start <= 1'b1;
                    state_r      <= flash_seq_pkg::S_PRUN;
                end
            end
            flash_seq_pkg::S_PRUN: begin
                if (i_op_done) begin
                    done_r  <= 1'b1;
                    state_r <= flash_seq_pkg::S_WAIT;
                    if (i_op_fail)
                        sts_r[flash_seq_pkg::ST_PRG] <= 1'b1;
                end
            end
            flash_seq_pkg::S_ERS2: begin
                if (wr_stb) begin
                    if (cmd_ers) begin
                        o_erase_start <= 1'b1;
                        done_r        <= 1'b0;
                        sel_r         <= flash_seq_pkg::OUT_POLL;
                        state_r       <= flash_seq_pkg::S_ERUN;
                    end else begin
                        sts_r[flash_seq_pkg::ST_CMD] <= 1'b1;
                        sel_r   <= flash_seq_pkg::OUT_STATUS;
                        state_r <= flash_seq_pkg::S_WAIT;
                    end
                end
            end
            flash_seq_pkg::S_ERUN: begin
                if (i_op_done) begin
                    done_r  <= 1'b1;
                    state_r <= flash_seq_pkg::S_WAIT;
                    if (i_op_fail)
                        sts_r[flash_seq_pkg::ST_ERS] <= 1'b1;
                end
            end
            flash_seq_pkg::S_STS2: begin
                if (wr_stb) begin
                    if (!cmd_sts)
                        sts_r[flash_seq_pkg::ST_CMD] <= 1'b1;
                    sel_r   <= flash_seq_pkg::OUT_STATUS;
                    state_r <= flash_seq_pkg::S_WAIT;
                end
            end
            default: state_r <= flash_seq_pkg::S_WAIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin side outputs and macro address
    wire [7:0] out_nxt = (sel_r == flash_seq_pkg::OUT_ARRAY)  ? i_mem_rdata :
                         (sel_r == flash_seq_pkg::OUT_POLL)   ? poll_byte :
                         (sel_r == flash_seq_pkg::OUT_STATUS) ? sts_byte :
                         8'h00;
    wire [ADDR_W-1:0] wr_addr = {base_r[ADDR_W-1:PB], ld_idx_r};

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data     <= 8'h00;
            o_data_oe  <= 1'b0;
            o_mem_addr <= '0;
            o_busy     <= 1'b0;
        end else begin
            o_data    <= out_nxt;
            o_data_oe <= ce_s & oe_s &
                         (state_r != flash_seq_pkg::S_SETUP);
            o_busy    <= (state_r == flash_seq_pkg::S_PRUN) |
                         (state_r == flash_seq_pkg::S_ERUN);
            if (skid_ld)
                o_mem_addr <= wr_addr;
            else if (state_r == flash_seq_pkg::S_READ)
                o_mem_addr <= addr_s;
        end
    end
endmodule // flash_seq

/* File: flash_seq_monitor.sv */
// assertions on the pins and macro side of the sequencer
// assumes it is bound to flash_seq, one clock, async low reset
`timescale 1ns/1ps
module flash_seq_monitor (
    input wire logic       i_sys_clk,     // clock
    input wire logic       i_nrst,        // reset
    input wire logic       i_ce_n,        // chip enable
    input wire logic       i_oe_n,        // output enable
    input wire logic [7:0] o_data,        // data out
    input wire logic       o_data_oe,     // data driven
    input wire logic       o_mem_wvalid,  // page byte valid
    input wire logic [7:0] o_mem_wdata,   // page byte
    input wire logic       i_mem_wready,  // macro ready
    input wire logic       o_prog_start,  // program pulse
    input wire logic       o_erase_start, // erase pulse
    input wire logic       i_op_done,     // op ended
    input wire logic       o_busy         // op running
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    a_prog_then_busy: assert property (o_prog_start |=> o_busy)
        else $error("busy missing after program start");
    a_erase_then_busy: assert property (o_erase_start |=> o_busy)
        else $error("busy missing after erase start");
    a_start_is_pulse: assert property ((o_prog_start || o_erase_start)
        |=> !(o_prog_start || o_erase_start))
        else $error("start pulse too long");
    a_busy_no_start: assert property (o_busy
        |-> !o_prog_start && !o_erase_start)
        else $error("new start while busy");
    a_poll_running: assert property (o_busy && $past(o_busy) && o_data_oe
        |-> o_data == 8'h00)
        else $error("polling byte wrong while running");
    a_done_ends_busy: assert property (o_busy && i_op_done
        |-> ##[1:2] !o_busy)
        else $error("busy held after done");
    a_wdata_held: assert property (o_mem_wvalid && !i_mem_wready
        |=> o_mem_wvalid && $stable(o_mem_wdata))
        else $error("page byte dropped while stalled");
    a_oe_off_idle: assert property (i_ce_n [*5] |-> !o_data_oe)
        else $error("data driven without chip enable");
    a_oe_on_read: assert property ((!i_ce_n && !i_oe_n) [*6]
        |-> o_data_oe)
        else $error("data not driven on read");
endmodule // flash_seq_monitor

bind flash_seq flash_seq_monitor u_mon (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_ce_n(i_ce_n), .i_oe_n(i_oe_n), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_mem_wvalid(o_mem_wvalid),
    .o_mem_wdata(o_mem_wdata), .i_mem_wready(i_mem_wready),
    .o_prog_start(o_prog_start), .o_erase_start(o_erase_start),
    .i_op_done(i_op_done), .o_busy(o_busy));

/* File: flash_seq_pkg.sv */
// constants, states and status layout of the programmer mode sequencer
// assumes one 125 MHz system clock and a flash macro beside the block
// Overview of operation
// - after program, erase or status read, return to the command wait state
// - memory read needs a read command first, except right after reset and setup; then reads repeat freely
// - in memory read mode commands are decoded as in command wait
// - after reset and setup time the block sits in memory read mode
// - auto-program takes 128 consecutive bytes before programming starts
// - misaligned program address still programs but flags a write error
// - address taken on the second cycle; later cycles carry data only
// - completion shows on bit seven, normal end on bit six
// - polling bits held until next command, driven with ce and oe low
// - auto-erase always clears the whole array
// - erase end shows on bit seven, normal end on bit six
// - bit seven of polling tells running from ended
// - bit six of polling tells normal from abnormal end
// - status code kept until a non status read command is taken
package flash_seq_pkg;
    localparam int CLK_KHZ        = 125000;
    localparam int SETUP_TIME_MS  = 10;
    localparam int SETUP_CYC      = SETUP_TIME_MS * CLK_KHZ;
    localparam int PAGE_BYTES     = 128;
    localparam int PAGE_LSB       = 7;
    localparam int ADDR_W         = 17;
    localparam int FIFO_DEPTH     = 8;
    localparam logic [7:0] CMD_PROG   = 8'h40;
    localparam logic [7:0] CMD_ERASE  = 8'h20;
    localparam logic [7:0] CMD_STATUS = 8'h71;
    localparam logic [7:0] CMD_READ   = 8'h00;
    localparam logic [7:0] STS_RST    = 8'h00;
    localparam int ST_ABN  = 7;
    localparam int ST_CMD  = 6;
    localparam int ST_PRG  = 5;
    localparam int ST_ERS  = 4;
    localparam int ST_OVC  = 1;
    localparam int ST_ADR  = 0;
    typedef enum logic [3:0] {
        S_SETUP, S_WAIT, S_READ, S_PADDR, S_PDATA, S_PDRAIN,
        S_PRUN, S_ERS2, S_ERUN, S_STS2
    } seq_state_e;
    typedef enum logic [1:0] {
        OUT_NONE, OUT_ARRAY, OUT_POLL, OUT_STATUS
    } out_sel_e;
endpackage

/* File: flash_seq_tb.sv */
// testbench of the programmer mode sequencer and its fifo
// assumes flash_seq_monitor is bound in; the bench plays the programmer
`timescale 1ns/1ps
module flash_seq_tb;
    localparam int SC = 20;
    logic clk = 0, nrst = 0, ce_n = 1, oe_n = 1, we_n = 1, fail = 0;
    logic [16:0] addr = '0, mem_addr, first, last;
    logic [7:0]  din = '0, dout, rdata, wdata, cnt, ldata, q;
    logic        doe, wvalid, wready, prog, erase, done, opfail, busy;
    logic        erased;
    int fail_count = 0, cmp_count = 0;

    always #4 clk = ~clk;
    flash_seq #(.SETUP_CYC(SC)) u_flash_seq (.i_sys_clk(clk),
        .i_nrst(nrst), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_addr(addr), .i_data(din), .o_data(dout), .o_data_oe(doe),
        .o_mem_addr(mem_addr), .i_mem_rdata(rdata), .o_mem_wvalid(wvalid),
        .o_mem_wdata(wdata), .i_mem_wready(wready), .o_prog_start(prog),
        .o_erase_start(erase), .i_op_done(done), .i_op_fail(opfail),
        .o_busy(busy));
    flash_macro_model u_flash_macro_model (.i_sys_clk(clk), .i_nrst(nrst),
        .i_addr(mem_addr), .i_wvalid(wvalid), .i_wdata(wdata),
        .i_prog(prog), .i_erase(erase), .i_fail(fail), .o_rdata(rdata),
        .o_wready(wready), .o_done(done), .o_fail(opfail), .o_cnt(cnt),
        .o_first(first), .o_last(last), .o_ldata(ldata), .o_erased(erased));

    ////////////////////////////////////////////////////////////////////
    task check(input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [16:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        din = d;
        ce_n = 0;
        we_n = 0;
        repeat (4) @(negedge clk);
        we_n = 1;
        repeat (5) @(negedge clk);
        ce_n = 1;
    endtask
    task rd(input logic [16:0] a);
        @(negedge clk);
        addr = a;
        ce_n = 0;
        oe_n = 0;
        repeat (8) @(negedge clk);
        q = dout;
        check(doe, 1);
        oe_n = 1;
        ce_n = 1;
        repeat (3) @(negedge clk);
    endtask
    task status;
        wr(0, 8'h71);
        wr(0, 8'h71);
        rd(0);
    endtask
    task wait_busy(input logic lvl);
        for (int n = 0; n < 300 && busy !== lvl; n++) @(negedge clk);
        check(busy, lvl);
    endtask
    // address stays on the pins after the second cycle, pads are all ones
    task page(input logic [16:0] base, input int used);
        wr(0, 8'h40);
        for (int i = 0; i < 128; i++) wr(base, i < used ? i : 8'hff);
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_boot;
        rd(17'h00012);
        check(q, 8'h12 ^ 8'h5a);
        rd(17'h1ff00);
        check(q, 8'h5a);
    endtask
    task t_cmd_err;
        wr(0, 8'h55);
        rd(0);
        check(q[6], 1);
        status;
        check(q[6], 1);
        wr(0, 8'h00);
        rd(17'h00005);
        check(q, 8'h05 ^ 8'h5a);
        status;
        check(q, 8'h00);
    endtask
    task t_prog;
        page(17'h00080, 100);
        wait_busy(1);
        check(cnt, 128);
        check(first, 17'h00080);
        check(last, 17'h000ff);
        check(ldata, 8'hff);
        rd(0);
        check(q, 8'h00);
        wait_busy(0);
        rd(0);
        check(q, 8'hc0);
        rd(0);
        check(q, 8'hc0);
        status;
        check(q, 8'h00);
    endtask
    task t_misalign;
        page(17'h00105, 128);
        wait_busy(1);
        check(first, 17'h00100);
        wait_busy(0);
        status;
        check({q[5], q[0]}, 2'b11);
    endtask
    task t_erase;
        fail = 1;
        wr(0, 8'h20);
        wr(0, 8'h20);
        wait_busy(1);
        check(erased, 1);
        wait_busy(0);
        fail = 0;
        rd(0);
        check(q, 8'h80);
        status;
        check({q[7], q[4]}, 2'b11);
    endtask
    // fifo path seen through the top: full page into the block after the failed erase of t_erase
    task t_fifo;
        page(17'h00080, 128);
        wait_busy(1);
        check(cnt, 128);
        check(last, 17'h000ff);
        check(ldata, 8'h7f);
        wait_busy(0);
        rd(0);
        check(q, 8'hc0);
    endtask

    ////////////////////////////////////////////////////////////////////
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        test_done;
    end
    initial begin
        repeat (5) @(negedge clk);
        nrst = 1;
        repeat (SC + 10) @(negedge clk);
        t_boot;
        t_cmd_err;
        t_prog;
        t_misalign;
        t_erase;
        t_fifo;
        test_done;
    end
endmodule // flash_seq_tb
